// ==== dps_map.svh ====
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// ==========================================================
// Timing of one pin cycle
// ==========================================================
// Clock period in ns (40 MHz)
`define DPS_CLK_NS 25
// Least strobe width on the read or write control, in ns
`define DPS_T_STROBE_NS 50
// Strobe width in clock cycles, rounded up, never below one
`define DPS_STROBE_CYC ((`DPS_T_STROBE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)

// ==========================================================
// Token space layout
// ==========================================================
// Number of tokens in the token space
`define DPS_TOKENS 8
// Highest token index
`define DPS_LAST_TOKEN 3'h7
// Width of the port address bus
`define DPS_ADDR_W 14
// Width of the port data bus
`define DPS_DATA_W 16
// Address lines above the token index, always driven low
`define DPS_ADDR_HI_W 11
// Data line that carries the token value sampled on a read
`define DPS_TOKEN_BIT 0

// ==========================================================
// Claim policy
// ==========================================================
// Read polls after a failed claim before the request is withdrawn
`define DPS_POLL_MAX 4'h8

`endif

// ==== dps_pkg.sv ====
package dps_pkg;

    // ==========================================================
    // Commands taken from the user port
    // ==========================================================
    typedef enum logic [1:0] {
        DPS_CMD_INIT    = 2'b00, // Free all tokens
        DPS_CMD_CLAIM   = 2'b01, // Write zero, then read back
        DPS_CMD_RELEASE = 2'b10, // Write one
        DPS_CMD_TEST    = 2'b11  // Read only
    } dps_cmd_t;

    // ==========================================================
    // Command sequencer states
    // ==========================================================
    typedef enum logic [3:0] {
        DPS_MS_IDLE     = 4'b0000,
        DPS_MS_INIT     = 4'b0001,
        DPS_MS_CLAIM_WR = 4'b0010,
        DPS_MS_CLAIM_RD = 4'b0011,
        DPS_MS_POLL     = 4'b0100,
        DPS_MS_WITHDRAW = 4'b0101,
        DPS_MS_RELEASE  = 4'b0110,
        DPS_MS_TEST     = 4'b0111,
        DPS_MS_FINISH   = 4'b1000
    } dps_mst_t;

    // ==========================================================
    // Pin cycle states
    // ==========================================================
    typedef enum logic [1:0] {
        DPS_SQ_IDLE    = 2'b00,
        DPS_SQ_SETUP   = 2'b01,
        DPS_SQ_STROBE  = 2'b10,
        DPS_SQ_RECOVER = 2'b11
    } dps_sst_t;

    // True for the states that issue a write cycle
    function automatic logic dps_is_write(input dps_mst_t st);
        return (st == DPS_MS_INIT) || (st == DPS_MS_CLAIM_WR) ||
               (st == DPS_MS_WITHDRAW) || (st == DPS_MS_RELEASE);
    endfunction

    // Value written by a write state: only a claim writes zero
    function automatic logic dps_write_value(input dps_mst_t st);
        return st != DPS_MS_CLAIM_WR;
    endfunction

endpackage

// ==== dps_cyc_if.sv ====
// ==========================================================
// One token access, handed from the command sequencer to the pins
// ==========================================================
interface dps_cyc_if;
    logic req;       // One-cycle start pulse
    logic wr;        // High for a write cycle
    logic [2:0] idx; // Token index
    logic wbit;      // Value to write
    logic done;      // One-cycle end pulse
    logic rbit;      // Value read back, valid with done

    modport ctl (output req, output wr, output idx, output wbit,
                 input done, input rbit);
    modport seq (input req, input wr, input idx, input wbit,
                 output done, output rbit);
endinterface

// ==== dps_pin_seq.sv ====
`include "dps_map.svh"

// ==========================================================
// Pin cycle generator: setup, strobe, recover
// ==========================================================
module dps_pin_seq
    import dps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    dps_cyc_if.seq cyc,
    output logic o_sem_n,
    output logic o_oe_n,
    output logic o_rw_n,
    output logic [`DPS_ADDR_W-1:0] o_addr,
    output logic [`DPS_DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [`DPS_DATA_W-1:0] i_data
);

    dps_sst_t st_reg;         // Cycle state
    logic [2:0] cnt_reg;      // Strobe cycles left
    logic wr_reg;             // Current cycle is a write
    logic done_reg;           // End pulse
    logic rbit_reg;           // Captured token value

    // Last cycle of the strobe
    wire strobe_last = (cnt_reg == 3'h0);
    // Strobe length minus one, at counter width
    wire [2:0] strobe_load = 3'(`DPS_STROBE_CYC - 1);

    assign cyc.done = done_reg;
    assign cyc.rbit = rbit_reg;

    // ==========================================================
    // Cycle state machine
    // ==========================================================
    // Select falls one cycle before the strobe and rises one after it,
    // so address and data are stable around the whole strobe
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= DPS_SQ_IDLE;
            cnt_reg <= 3'h0;
            wr_reg <= 1'b0;
            done_reg <= 1'b0;
            rbit_reg <= 1'b1;
            o_sem_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_rw_n <= 1'b1;
            o_addr <= '0;
            o_data <= '0;
            o_data_oe <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (st_reg)
                DPS_SQ_IDLE: begin
                    // Token access through the token select only
                    if (cyc.req) begin
                        o_addr <= {`DPS_ADDR_HI_W'(0), cyc.idx};
                        o_data <= {`DPS_DATA_W{cyc.wbit}};
                        o_data_oe <= cyc.wr;
                        wr_reg <= cyc.wr;
                        o_sem_n <= 1'b0;
                        st_reg <= DPS_SQ_SETUP;
                    end
                end
                DPS_SQ_SETUP: begin
                    // Write strobes the read/write line, read the output enable
                    if (wr_reg) begin
                        o_rw_n <= 1'b0;
                    end else begin
                        o_oe_n <= 1'b0;
                    end
                    cnt_reg <= strobe_load;
                    st_reg <= DPS_SQ_STROBE;
                end
                DPS_SQ_STROBE: begin
                    if (strobe_last) begin
                        o_rw_n <= 1'b1;
                        o_oe_n <= 1'b1;
                        // Every data line carries the token; one line suffices
                        if (!wr_reg) begin
                            rbit_reg <= i_data[`DPS_TOKEN_BIT];
                        end
                        st_reg <= DPS_SQ_RECOVER;
                    end else begin
                        cnt_reg <= cnt_reg - 3'h1;
                    end
                end
                DPS_SQ_RECOVER: begin
                    // Select goes inactive after every access, so the device's
                    // read latch reopens before the next poll
                    o_sem_n <= 1'b1;
                    o_data_oe <= 1'b0;
                    done_reg <= 1'b1;
                    st_reg <= DPS_SQ_IDLE;
                end
                default: begin
                    st_reg <= DPS_SQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_strobe_under_select: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!o_rw_n || !o_oe_n) |-> !o_sem_n && !$past(o_sem_n))
        else $error("strobe active without token select held");

    chk_select_drops_after: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ($rose(o_oe_n) || $rose(o_rw_n)) |=> o_sem_n && o_oe_n && o_rw_n)
        else $error("token select not released between accesses");

endmodule

// ==== dps_port_ctl.sv ====
`include "dps_map.svh"


// ==========================================================
// Port-side token controller for one port of the semaphore unit
// ==========================================================
module dps_port_ctl
    import dps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd,
    input wire logic [2:0] i_index,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_granted,
    output logic o_token_bit,
    output logic o_token_space_select_n,
    output logic o_array_select_n,
    output logic o_oe_n,
    output logic o_rw_n,
    output logic [`DPS_ADDR_W-1:0] o_addr,
    output logic [`DPS_DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [`DPS_DATA_W-1:0] i_data
);

    dps_cyc_if cyc ();

    dps_mst_t st_reg;        // Command state
    logic pend_reg;          // A pin cycle is in flight
    logic req_reg;           // Start pulse to the pin cycle
    logic wr_reg;            // Cycle kind
    logic wbit_reg;          // Value to write
    logic [2:0] idx_reg;     // Token being worked on
    logic [3:0] poll_reg;    // Polls done after a failed claim
    logic granted_reg;       // This port holds the token
    logic tbit_reg;          // Last value read back
    logic done_reg;          // Command end pulse
    logic ready_reg;         // Command port idle
    logic arr_n_reg;         // Array select, kept high

    // ==========================================================
    // Decoding
    // ==========================================================
    wire dps_cmd_t cmd = dps_cmd_t'(i_cmd);
    wire st_write = dps_is_write(st_reg);
    wire st_wbit = dps_write_value(st_reg);
    wire last_token = (idx_reg == `DPS_LAST_TOKEN);
    wire poll_spent = (poll_reg == `DPS_POLL_MAX);
    wire cyc_end = pend_reg && cyc.done;
    wire token_won = !cyc.rbit;
    wire dps_mst_t cmd_state =
        (cmd == DPS_CMD_INIT) ? DPS_MS_INIT :
        (cmd == DPS_CMD_CLAIM) ? DPS_MS_CLAIM_WR :
        (cmd == DPS_CMD_RELEASE) ? DPS_MS_RELEASE : DPS_MS_TEST;
    wire active = (st_reg != DPS_MS_IDLE) && (st_reg != DPS_MS_FINISH);

    assign cyc.req = req_reg;
    assign cyc.wr = wr_reg;
    assign cyc.idx = idx_reg;
    assign cyc.wbit = wbit_reg;

    assign o_cmd_ready = ready_reg;
    assign o_done = done_reg;
    assign o_granted = granted_reg;
    assign o_token_bit = tbit_reg;
    assign o_array_select_n = arr_n_reg;

    // ==========================================================
    // Pin cycle generator
    // ==========================================================
    dps_pin_seq u_seq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .cyc(cyc.seq),
        .o_sem_n(o_token_space_select_n),
        .o_oe_n(o_oe_n),
        .o_rw_n(o_rw_n),
        .o_addr(o_addr),
        .o_data(o_data),
        .o_data_oe(o_data_oe),
        .i_data(i_data)
    );

    // ==========================================================
    // Cycle issue: a new pin cycle whenever a command state is active and none is in flight
    // ==========================================================
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            req_reg <= 1'b0;
            pend_reg <= 1'b0;
            wr_reg <= 1'b0;
            wbit_reg <= 1'b1;
        end else begin
            req_reg <= active && !pend_reg;
            if (active && !pend_reg) begin
                pend_reg <= 1'b1;
                wr_reg <= st_write;
                // Zero requests the token, one frees or withdraws it
                wbit_reg <= st_wbit;
            end else if (cyc_end) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Command state machine
    // ==========================================================
    // The array select never goes low: this block only touches tokens
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= DPS_MS_IDLE;
            idx_reg <= 3'h0;
            poll_reg <= 4'h0;
            granted_reg <= 1'b0;
            tbit_reg <= 1'b1;
            done_reg <= 1'b0;
            ready_reg <= 1'b0;
            arr_n_reg <= 1'b1;
        end else begin
            done_reg <= 1'b0;
            case (st_reg)
                DPS_MS_IDLE: begin
                    ready_reg <= 1'b1;
                    if (i_cmd_valid && ready_reg) begin
                        ready_reg <= 1'b0;
                        idx_reg <= (cmd == DPS_CMD_INIT) ? 3'h0 : i_index;
                        poll_reg <= 4'h0;
                        st_reg <= cmd_state;
                    end
                end
                DPS_MS_INIT: begin
                    // Walk every token writing one; tokens start undefined
                    if (cyc_end) begin
                        granted_reg <= 1'b0;
                        if (last_token) begin
                            st_reg <= DPS_MS_FINISH;
                        end else begin
                            idx_reg <= idx_reg + 3'h1;
                        end
                    end
                end
                DPS_MS_CLAIM_WR: begin
                    // The write of zero always comes before the
                    if (cyc_end) begin
                        st_reg <= DPS_MS_CLAIM_RD;
                    end
                end
                DPS_MS_CLAIM_RD, DPS_MS_POLL: begin
                    if (cyc_end) begin
                        tbit_reg <= cyc.rbit;
                        if (token_won) begin
                            granted_reg <= 1'b1;
                            st_reg <= DPS_MS_FINISH;
                        end else if (poll_spent) begin
                            // Leaving a zero pending would hang the peer
                            st_reg <= DPS_MS_WITHDRAW;
                        end else begin
                            poll_reg <= poll_reg + 4'h1;
                            st_reg <= DPS_MS_POLL;
                        end
                    end
                end
                DPS_MS_WITHDRAW, DPS_MS_RELEASE: begin
                    if (cyc_end) begin
                        granted_reg <= 1'b0;
                        st_reg <= DPS_MS_FINISH;
                    end
                end
                DPS_MS_TEST: begin
                    if (cyc_end) begin
                        tbit_reg <= cyc.rbit;
                        granted_reg <= token_won;
                        st_reg <= DPS_MS_FINISH;
                    end
                end
                DPS_MS_FINISH: begin
                    done_reg <= 1'b1;
                    st_reg <= DPS_MS_IDLE;
                end
                default: begin
                    st_reg <= DPS_MS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_claim_write_first: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_reg == DPS_MS_CLAIM_RD) && $changed(st_reg) |->
            $past(st_reg) == DPS_MS_CLAIM_WR && !wbit_reg && wr_reg)
        else $error("claim read not preceded by a zero write");

    chk_claim_wbit_zero: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        req_reg && (st_reg == DPS_MS_CLAIM_WR) |-> wr_reg && !wbit_reg)
        else $error("claim cycle does not write zero");

    chk_init_all_tokens: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_reg == DPS_MS_INIT) && cyc_end |->
            wr_reg && wbit_reg ##1 ($past(last_token) ? st_reg == DPS_MS_FINISH
                                    : st_reg == DPS_MS_INIT))
        else $error("init does not write one to every token");

    chk_withdraw_ones: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_reg == DPS_MS_WITHDRAW) && cyc_end |-> wr_reg && wbit_reg
            ##1 !granted_reg ##1 done_reg)
        else $error("withdraw does not write one or report");

    chk_poll_bounded: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_reg == DPS_MS_POLL) && cyc_end && !token_won && poll_spent
            |=> st_reg == DPS_MS_WITHDRAW)
        else $error("poll limit not followed by withdraw");

    chk_array_idle: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !o_token_space_select_n |-> o_array_select_n)
        else $error("array select low during token access");

endmodule

// ==== dps_sem_model.sv ====
// ==========================================================
// Behavioural token unit with two ports: index 0 left, 1 right
// ==========================================================
module dps_sem_model (
    input wire logic [1:0] i_sem_n,
    input wire logic [1:0] i_ce_n,
    input wire logic [1:0] i_oe_n,
    input wire logic [1:0] i_rw_n,
    input wire logic [1:0][13:0] i_addr,
    input wire logic [1:0][15:0] i_data,
    output logic [1:0][15:0] o_data,
    output logic [1:0] o_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] req [2]; // Request latch per port, one means no request
    logic [7:0] own [2]; // Port that holds each token, kept apart from any array
    logic [15:0] q [2]; // Output holding latch per port

    // Free a released token, then hand it to a waiting zero; left first on a tie
    task automatic settle(input int t);
        if (own[0][t] && req[0][t]) own[0][t] = 1'b0;
        if (own[1][t] && req[1][t]) own[1][t] = 1'b0;
        if (!own[0][t] && !own[1][t]) begin
            if (!req[0][t]) own[0][t] = 1'b1;
            else if (!req[1][t]) own[1][t] = 1'b1;
        end
    endtask

    // Power-up state is free here; the controller must not count on it
    initial begin
        req[0] = 8'hff;
        req[1] = 8'hff;
        own[0] = 8'h00;
        own[1] = 8'h00;
        q[0] = 16'h0000;
        q[1] = 16'h0000;
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        wire sel;
        // Token space needs select low and array select high
        assign sel = !i_sem_n[p] && i_ce_n[p];
        // Write lands as the write strobe ends; low index lines, bit zero only
        always @(posedge i_rw_n[p]) begin
            if (sel) begin
                req[p][i_addr[p][2:0]] = i_data[p][0];
                settle(int'(i_addr[p][2:0]));
            end
        end
        // Capture once both controls go active, so a poll must toggle one
        always @(negedge (i_sem_n[p] | i_oe_n[p])) begin
            if (sel) q[p] = {16{~own[p][i_addr[p][2:0]]}};
        end
        assign o_data[p] = q[p];
        assign o_data_oe[p] = sel && !i_oe_n[p] && i_rw_n[p];
    end
endmodule

// ==== testbench.sv ====
`include "dps_map.svh"

// ==========================================================
// Bench: controller on the left port, bench drives the right port
// ==========================================================
module testbench
    import dps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk, i_sys_rst, i_cmd_valid;
    logic [1:0] i_cmd;
    logic [2:0] i_index;
    logic o_cmd_ready, o_done, o_granted, o_token_bit;
    logic sel_n, ce_n, oe_n, rw_n, o_data_oe;
    logic [13:0] o_addr, r_addr;
    logic [15:0] o_data;
    wire [15:0] i_data; // Left data bus as the controller sees it
    wire [15:0] dev_in; // Left data bus as the device sees it
    logic r_sem_n, r_ce_n, r_oe_n, r_rw_n; // Right port controls
    logic [15:0] r_wdata;
    logic [1:0][15:0] dev_q;
    logic [1:0] dev_oe;
    logic [15:0] fill; // Toggles, so a released bus never looks valid
    logic [15:0] last_w; // Last word the controller wrote
    int n_errors = 0;
    int compares = 0;
    int n_wr = 0;
    int n_rd = 0;
    int cyc = 0;

    assign i_data = dev_oe[0] ? dev_q[0] : (o_data_oe ? o_data : fill);
    assign dev_in = o_data_oe ? o_data : fill;

    dps_port_ctl u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .i_index(i_index), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
        .o_granted(o_granted), .o_token_bit(o_token_bit), .o_token_space_select_n(sel_n),
        .o_array_select_n(ce_n), .o_oe_n(oe_n), .o_rw_n(rw_n), .o_addr(o_addr),
        .o_data(o_data), .o_data_oe(o_data_oe), .i_data(i_data));

    dps_sem_model u_model (.i_sem_n({r_sem_n, sel_n}), .i_ce_n({r_ce_n, ce_n}),
        .i_oe_n({r_oe_n, oe_n}), .i_rw_n({r_rw_n, rw_n}), .i_addr({r_addr, o_addr}),
        .i_data({r_wdata, dev_in}), .o_data(dev_q), .o_data_oe(dev_oe));

    // ==========================================================
    // Clock, bus filler, pin monitors and hang limit
    // ==========================================================
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) fill <= ~fill;
    // Count token writes and reads as strobes end
    always @(posedge rw_n) if (sel_n === 1'b0) begin
        n_wr++;
        last_w = o_data;
    end
    always @(posedge oe_n) if (sel_n === 1'b0) n_rd++;
    // Whole run needs well under two thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            test_done();
        end
    end

    // ==========================================================
    // Report and compare tasks
    // ==========================================================
    task automatic test_done();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // ==========================================================
    // Drivers: command port and right port
    // ==========================================================
    // Hold valid over the taking edge; wait for done, bounded
    task automatic cmd(input dps_cmd_t c, input logic [2:0] t);
        int k;
        k = 0;
        @(negedge i_clk);
        while (o_cmd_ready !== 1'b1 && k < 200) begin
            @(negedge i_clk);
            k++;
        end
        i_cmd_valid = 1'b1;
        i_cmd = c;
        i_index = t;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
        while (o_done !== 1'b1 && k < 400) begin
            @(negedge i_clk);
            k++;
        end
        chk1("done", 1'b1, o_done);
    endtask
    // Right port write; the bus is inverted once released
    task automatic r_write(input logic [13:0] a, input logic [15:0] d, input logic s_n);
        @(negedge i_clk);
        r_sem_n = s_n;
        r_addr = a;
        r_wdata = d;
        @(negedge i_clk);
        r_rw_n = 1'b0;
        repeat (2) @(negedge i_clk);
        r_rw_n = 1'b1;
        @(negedge i_clk);
        r_sem_n = 1'b1;
        r_wdata = ~d;
    endtask
    // Right port read held, then compared
    task automatic r_chk(input logic [2:0] t, input int hold, input logic [15:0] exp,
                         input string nm);
        logic [15:0] v;
        @(negedge i_clk);
        r_sem_n = 1'b0;
        r_addr = {11'h000, t};
        @(negedge i_clk);
        r_oe_n = 1'b0;
        repeat (hold) @(negedge i_clk);
        v = dev_oe[1] ? dev_q[1] : fill;
        r_oe_n = 1'b1;
        r_sem_n = 1'b1;
        chk16(nm, exp, v);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        chk1("ready", 1'b1, o_cmd_ready); // Idle after reset
        chk1("granted", 1'b0, o_granted); // Nothing owned
        chk1("select_n", 1'b1, sel_n); // No access yet
        chk1("data_oe", 1'b0, o_data_oe); // Bus released
    endtask
    task automatic t_init();
        for (int t = 0; t < 8; t++) r_write(14'(t), 16'hffff, 1'b0); // Right frees all
        n_wr = 0;
        cmd(DPS_CMD_INIT, 3'h0);
        chk16("init writes", 16'h0008, 16'(n_wr)); // One per token
        chk16("init data", 16'hffff, last_w); // Ones on all lines
        chk16("addr", 16'h0007, 16'(o_addr)); // High lines low
        chk1("array select", 1'b1, ce_n); // Array never touched
        r_chk(3'h7, 2, 16'hffff, "free after init"); // Free
    endtask
    task automatic t_claim_free();
        cmd(DPS_CMD_CLAIM, 3'h3);
        chk1("claim granted", 1'b1, o_granted); // Write then read back
        chk1("claim bit", 1'b0, o_token_bit); // Owner reads zero
        r_chk(3'h3, 2, 16'hffff, "other side"); // Other reads ones
    endtask
    task automatic t_handover();
        r_write(14'h0003, 16'h0000, 1'b0);
        r_chk(3'h3, 2, 16'hffff, "pending"); // Request only latched
        cmd(DPS_CMD_TEST, 3'h3);
        chk1("owner kept", 1'b0, o_token_bit); // Owner unaffected
        cmd(DPS_CMD_RELEASE, 3'h3);
        chk1("released", 1'b0, o_granted); // Release by one
        r_chk(3'h3, 2, 16'h0000, "passed"); // Passes at once
        cmd(DPS_CMD_TEST, 3'h3);
        chk1("lost", 1'b1, o_token_bit); // New owner holds
        r_write(14'h0003, 16'hffff, 1'b0);
        r_chk(3'h3, 2, 16'hffff, "freed"); // Free again
    endtask
    task automatic t_withdraw();
        r_write(14'h0005, 16'h0000, 1'b0);
        n_rd = 0;
        n_wr = 0;
        cmd(DPS_CMD_CLAIM, 3'h5);
        chk1("fail granted", 1'b0, o_granted); // Claim fails
        chk16("poll reads", 16'(`DPS_POLL_MAX) + 16'h0001, 16'(n_rd)); // Bounded poll
        chk16("fail writes", 16'h0002, 16'(n_wr)); // Claim and withdraw
        chk16("withdraw data", 16'hffff, last_w); // Withdraw by one
        r_write(14'h0005, 16'hffff, 1'b0);
        cmd(DPS_CMD_TEST, 3'h5);
        chk1("no stale win", 1'b1, o_token_bit); // Request gone
    endtask
    task automatic t_late_win();
        r_write(14'h0006, 16'h0000, 1'b0);
        fork
            cmd(DPS_CMD_CLAIM, 3'h6);
            begin
                repeat (30) @(negedge i_clk);
                r_write(14'h0006, 16'hffff, 1'b0);
            end
        join
        chk1("late granted", 1'b1, o_granted); // Poll sees handover
        chk1("late bit", 1'b0, o_token_bit); // Fresh read per poll
        cmd(DPS_CMD_RELEASE, 3'h6);
    endtask
    task automatic t_latch();
        cmd(DPS_CMD_CLAIM, 3'h4);
        r_write(14'h0004, 16'h0000, 1'b0);
        fork
            r_chk(3'h4, 24, 16'hffff, "held read"); // Latched value holds
            begin
                repeat (3) @(negedge i_clk);
                cmd(DPS_CMD_RELEASE, 3'h4);
            end
        join
        r_chk(3'h4, 2, 16'h0000, "reread"); // Reopened latch
        r_write(14'h0004, 16'hffff, 1'b0);
    endtask
    task automatic t_wide();
        r_write(14'h3ff9, 16'hfffe, 1'b0);
        r_write(14'h0002, 16'h0000, 1'b1);
        cmd(DPS_CMD_CLAIM, 3'h1);
        chk1("high lines", 1'b0, o_granted); // Low lines pick token
        cmd(DPS_CMD_CLAIM, 3'h2);
        chk1("standby", 1'b1, o_granted); // Deselected write ignored
        r_write(14'h2001, 16'h8001, 1'b0);
        r_chk(3'h1, 2, 16'hffff, "bit zero"); // Only bit zero counts
        cmd(DPS_CMD_RELEASE, 3'h2);
        chk1("release", 1'b0, o_granted); // Release by one
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        i_sys_rst = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd = 2'b00;
        i_index = 3'h0;
        r_sem_n = 1'b1;
        r_ce_n = 1'b1;
        r_oe_n = 1'b1;
        r_rw_n = 1'b1;
        r_addr = 14'h0000;
        r_wdata = 16'h0000;
        fill = 16'h5a5a;
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (2) @(negedge i_clk);
        t_reset();
        t_init();
        t_claim_free();
        t_handover();
        t_withdraw();
        t_late_win();
        t_latch();
        t_wide();
        test_done();
    end
endmodule
